/* File: design/ssf_sample_buffer.sv */
// sample buffer of a three-axis motion sensor with four policies
//
// Overview of operation
// - The buffer memory holds exactly 512 entries of one value each.
// - That room fits 170 sets of three axes or 128 sets with temperature.
// - Policy 00 stores nothing and discards every entry held.
// - Policy 01 fills until full, then drops new entries until reads.
// - Policy 10 drops the oldest entry to make room when full.
// - The watermark event rises when fill reaches the programmed count.
// - Policy 11 keeps the programmed count before activity, then fills.
// - The outside clock select bit times sampling from pin one while the sync sampling bit is clear.
// - The sync sampling bit takes one sample per trigger on pin two.
// - Sets are written X, Y, Z then temperature, partial sets allowed.
// - Entries carry 12 data bits, 2 sign bits and a 2-bit type code.
// - Entries are read low byte first; an empty buffer returns 0x00.
`timescale 1ns/1ns
`default_nettype none
module ssf_sample_buffer
  import ssf_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES,
  parameter int EXT_DIV_P       = 1
) (
  // clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              sys_rst_in,
  // register port
  input  wire logic              reg_wr_en_in,
  input  wire logic              reg_rd_en_in,
  input  wire logic [7:0]        reg_addr_in,
  input  wire logic [7:0]        reg_wdata_in,
  output logic      [7:0]        reg_rdata_out,
  // buffer byte read port
  input  wire logic              buf_rd_in,
  output logic      [7:0]        buf_byte_out,
  // sensor front end
  input  wire logic [DATA_W-1:0] axis_x_in,
  input  wire logic [DATA_W-1:0] axis_y_in,
  input  wire logic [DATA_W-1:0] axis_z_in,
  input  wire logic [DATA_W-1:0] temp_in,
  input  wire logic              activity_in,
  // timing pins
  input  wire logic              irq_pin_one_in,
  input  wire logic              irq_pin_two_in,
  // events
  output logic                   watermark_out,
  output logic                   overrun_out,
  output logic                   sample_tick_out
);
  localparam logic [CNT_W-1:0] FULL_CNT  = CNT_W'(BUF_DEPTH);
  localparam logic [PTR_W-1:0] LAST_SLOT = PTR_W'(BUF_DEPTH - 1);
  localparam int SET_ROOM_AXES = SETS_AXES * 3;
  localparam int SET_ROOM_TEMP = SETS_TEMP * 4;

  // registers
  logic [7:0] buffer_control_register;
  logic [7:0] watermark_count_register;
  logic [7:0] rate_range_control_register;
  logic [7:0] power_control_register;
  logic [7:0] event_enable_register;

  // decoded controls
  ssf_mode_t        mode;
  logic             temp_en;
  logic             measuring;
  logic             outside_clock_select;
  logic             sync_sampling_select;
  logic [PTR_W-1:0] wm_level;

  // buffer state
  logic [ENTRY_W-1:0] mem [BUF_DEPTH];
  logic [PTR_W-1:0]   wr_ptr;
  logic [PTR_W-1:0]   rd_ptr;
  logic [CNT_W-1:0]   count;
  logic               triggered;
  logic               byte_hi;
  logic [7:0]         hi_latch;

  // sampling and sequencing
  logic [2:0]        pin1_sync;
  logic [2:0]        pin2_sync;
  logic              pin1_rise;
  logic              pin2_rise;
  logic [31:0]       rate_cnt;
  logic [31:0]       ext_cnt;
  logic              sample_tick;
  ssf_seq_t          seq_state;
  logic [DATA_W-1:0] hold_x;
  logic [DATA_W-1:0] hold_y;
  logic [DATA_W-1:0] hold_z;
  logic [DATA_W-1:0] hold_t;

  // memory writer controls
  logic full;
  logic flush;
  logic accept;
  logic do_write;
  logic drop_old;
  logic pop;

  ssf_stream_if #(.WIDTH(ENTRY_W)) stage_in_if ();
  ssf_stream_if #(.WIDTH(ENTRY_W)) stage_out_if ();

  // builds one tagged entry with sign extension
  function automatic logic [ENTRY_W-1:0] make_entry(
    input logic [1:0]        kind,
    input logic [DATA_W-1:0] value
  );
    make_entry = {kind, value[DATA_W-1], value[DATA_W-1], value};
  endfunction

  // control decode
  assign mode      = ssf_mode_t'(buffer_control_register[MODE_LSB +: 2]);
  assign temp_en   = buffer_control_register[TEMP_BIT];
  assign measuring = power_control_register[MEAS_LSB +: 2] == MEASURE_ON;
  assign outside_clock_select = power_control_register[OUTSIDE_CLOCK_SELECT_BIT];
  assign sync_sampling_select = rate_range_control_register[SYNC_BIT];
  assign wm_level  = {buffer_control_register[HIGH_BIT],
                      watermark_count_register};

  // register writes, host sets timing bits last
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      buffer_control_register     <= REG_RST;
      watermark_count_register    <= REG_RST;
      rate_range_control_register <= REG_RST;
      power_control_register      <= REG_RST;
      event_enable_register       <= REG_RST;
    end else if (reg_wr_en_in) begin
      if (reg_addr_in == ADDR_BUF_CTRL) begin
        buffer_control_register <= reg_wdata_in;
      end else if (reg_addr_in == ADDR_WM_COUNT) begin
        watermark_count_register <= reg_wdata_in;
      end else if (reg_addr_in == ADDR_RATE_CTRL) begin
        rate_range_control_register <= reg_wdata_in;
      end else if (reg_addr_in == ADDR_POWER_CTRL) begin
        power_control_register <= reg_wdata_in;
      end else if (reg_addr_in == ADDR_EVENT_EN) begin
        event_enable_register <= reg_wdata_in;
      end
    end
  end

  // register reads, unmapped addresses return zero
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      reg_rdata_out <= REG_RST;
    end else if (reg_rd_en_in) begin
      if (reg_addr_in == ADDR_BUF_CTRL) begin
        reg_rdata_out <= buffer_control_register;
      end else if (reg_addr_in == ADDR_WM_COUNT) begin
        reg_rdata_out <= watermark_count_register;
      end else if (reg_addr_in == ADDR_RATE_CTRL) begin
        reg_rdata_out <= rate_range_control_register;
      end else if (reg_addr_in == ADDR_POWER_CTRL) begin
        reg_rdata_out <= power_control_register;
      end else if (reg_addr_in == ADDR_EVENT_EN) begin
        reg_rdata_out <= event_enable_register;
      end else if (reg_addr_in == ADDR_FILL_LO) begin
        reg_rdata_out <= count[7:0];
      end else if (reg_addr_in == ADDR_FILL_HI) begin
        reg_rdata_out <= {6'h00, count[CNT_W-1:8]};
      end else if (reg_addr_in == ADDR_STATUS) begin
        reg_rdata_out <= REG_RST;
        reg_rdata_out[ST_READY_BIT] <= count != '0;
        reg_rdata_out[ST_WM_BIT]    <= watermark_out;
        reg_rdata_out[ST_OVR_BIT]   <= overrun_out;
      end else begin
        reg_rdata_out <= REG_RST;
      end
    end
  end

  // two-stage synchronisers plus edge history on the timing pins
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      pin1_sync <= 3'h0;
      pin2_sync <= 3'h0;
    end else begin
      pin1_sync <= {pin1_sync[1:0], irq_pin_one_in};
      pin2_sync <= {pin2_sync[1:0], irq_pin_two_in};
    end
  end
  assign pin1_rise = pin1_sync[1] && !pin1_sync[2];
  assign pin2_rise = pin2_sync[1] && !pin2_sync[2];

  // sample timing source selection
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      rate_cnt    <= 32'h0;
      ext_cnt     <= 32'h0;
      sample_tick <= 1'b0;
    end else begin
      sample_tick <= 1'b0;
      if (!measuring) begin
        rate_cnt <= 32'h0;
        ext_cnt  <= 32'h0;
      end else if (sync_sampling_select) begin
        sample_tick <= pin2_rise;
      end else if (outside_clock_select) begin
        if (pin1_rise) begin
          if (ext_cnt >= 32'(EXT_DIV_P - 1)) begin
            ext_cnt     <= 32'h0;
            sample_tick <= 1'b1;
          end else begin
            ext_cnt <= ext_cnt + 32'h1;
          end
        end
      end else if (rate_cnt >= 32'(SAMPLE_CYCLES_P - 1)) begin
        rate_cnt    <= 32'h0;
        sample_tick <= 1'b1;
      end else begin
        rate_cnt <= rate_cnt + 32'h1;
      end
    end
  end

  // set sequencer holding one captured sample
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      seq_state <= SSF_SEQ_IDLE;
      hold_x    <= '0;
      hold_y    <= '0;
      hold_z    <= '0;
      hold_t    <= '0;
    end else if (mode == SSF_MODE_OFF) begin
      seq_state <= SSF_SEQ_IDLE;
    end else begin
      case (seq_state)
        SSF_SEQ_IDLE: begin
          if (sample_tick) begin
            hold_x    <= axis_x_in;
            hold_y    <= axis_y_in;
            hold_z    <= axis_z_in;
            hold_t    <= temp_in;
            seq_state <= SSF_SEQ_X;
          end
        end
        SSF_SEQ_X: begin
          if (stage_in_if.ready) begin
            seq_state <= SSF_SEQ_Y;
          end
        end
        SSF_SEQ_Y: begin
          if (stage_in_if.ready) begin
            seq_state <= SSF_SEQ_Z;
          end
        end
        SSF_SEQ_Z: begin
          if (stage_in_if.ready) begin
            seq_state <= temp_en ? SSF_SEQ_T : SSF_SEQ_IDLE;
          end
        end
        SSF_SEQ_T: begin
          if (stage_in_if.ready) begin
            seq_state <= SSF_SEQ_IDLE;
          end
        end
        default: begin
          seq_state <= SSF_SEQ_IDLE;
        end
      endcase
    end
  end

  // entry offered to the staging fifo
  always_comb begin
    stage_in_if.valid = seq_state != SSF_SEQ_IDLE;
    case (seq_state)
      SSF_SEQ_Y: stage_in_if.data = make_entry(TYPE_Y, hold_y);
      SSF_SEQ_Z: stage_in_if.data = make_entry(TYPE_Z, hold_z);
      SSF_SEQ_T: stage_in_if.data = make_entry(TYPE_T, hold_t);
      default:   stage_in_if.data = make_entry(TYPE_X, hold_x);
    endcase
  end

  ssf_stage_fifo #(
    .WIDTH (ENTRY_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .sys_clk_in (sys_clk_in),
    .sys_rst_in (sys_rst_in),
    .flush_in   (flush),
    .push_if    (stage_in_if),
    .pop_if     (stage_out_if)
  );

  // policy decision for each drained entry
  assign flush = mode == SSF_MODE_OFF;
  assign full  = count == FULL_CNT;
  assign pop   = buf_rd_in && !byte_hi && (count != '0) && !flush;
  assign stage_out_if.ready = !buf_rd_in; // host read stalls the drain
  assign accept = stage_out_if.valid && stage_out_if.ready;
  always_comb begin
    do_write = 1'b0;
    drop_old = 1'b0;
    case (mode)
      SSF_MODE_OLDEST: begin
        do_write = accept && !full;
      end
      SSF_MODE_STREAM: begin
        do_write = accept;
        drop_old = accept && full;
      end
      SSF_MODE_TRIG: begin
        if (triggered) begin
          do_write = accept && !full;
        end else begin
          do_write = accept && (wm_level != '0);
          drop_old = do_write && (count >= CNT_W'(wm_level));
        end
      end
      default: begin
        do_write = 1'b0;
      end
    endcase
  end

  // buffer memory write
  always_ff @(posedge sys_clk_in) begin
    if (do_write) begin
      mem[wr_ptr] <= stage_out_if.data;
    end
  end

  // buffer pointers and fill level
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_write) begin
        wr_ptr <= (wr_ptr == LAST_SLOT) ? '0 : wr_ptr + 1'b1;
      end
      if (drop_old || pop) begin
        rd_ptr <= (rd_ptr == LAST_SLOT) ? '0 : rd_ptr + 1'b1;
      end
      if (do_write && !drop_old) begin
        count <= count + 1'b1;
      end else if (pop) begin
        count <= count - 1'b1;
      end
    end
  end

  // one-shot trigger latch and overrun flag, an overrun set beats its clear
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      triggered   <= 1'b0;
      overrun_out <= 1'b0;
    end else begin
      if (mode != SSF_MODE_TRIG) begin
        triggered <= 1'b0;
      end else if (activity_in) begin
        triggered <= 1'b1;
      end
      if (accept && !do_write && mode != SSF_MODE_OFF) begin
        overrun_out <= 1'b1;
      end else if (pop || flush) begin
        overrun_out <= 1'b0;
      end
    end
  end

  // watermark level event
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      watermark_out <= 1'b0;
    end else begin
      watermark_out <= event_enable_register[WM_EN_BIT] &&
                       (wm_level != '0) &&
                       (count >= CNT_W'(wm_level));
    end
  end

  // host byte reads, low byte pops the entry
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      byte_hi      <= 1'b0;
      hi_latch     <= EMPTY_BYTE;
      buf_byte_out <= EMPTY_BYTE;
    end else if (flush) begin
      byte_hi <= 1'b0;
      if (buf_rd_in) begin
        buf_byte_out <= EMPTY_BYTE;
      end
    end else if (buf_rd_in) begin
      byte_hi <= !byte_hi;
      if (byte_hi) begin
        buf_byte_out <= hi_latch;
      end else if (count != '0) begin
        buf_byte_out <= mem[rd_ptr][7:0];
        hi_latch     <= mem[rd_ptr][15:8];
      end else begin
        buf_byte_out <= EMPTY_BYTE;
        hi_latch     <= EMPTY_BYTE;
      end
    end
  end

  // sample tick made visible
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sample_tick_out <= 1'b0;
    end else begin
      sample_tick_out <= sample_tick;
    end
  end

  // room check: both set sizes fit the memory
  localparam bit ROOM_OK = (SET_ROOM_AXES <= BUF_DEPTH) &&
                           (SET_ROOM_TEMP <= BUF_DEPTH);
endmodule
`default_nettype wire

/* File: design/ssf_pkg.sv */
// shared constants and types of the sensor sample buffer
package ssf_pkg;

  // register addresses
  localparam logic [7:0] ADDR_STATUS     = 8'h0B;
  localparam logic [7:0] ADDR_FILL_LO    = 8'h0C;
  localparam logic [7:0] ADDR_FILL_HI    = 8'h0D;
  localparam logic [7:0] ADDR_BUF_CTRL   = 8'h28;
  localparam logic [7:0] ADDR_WM_COUNT   = 8'h29;
  localparam logic [7:0] ADDR_RATE_CTRL  = 8'h2C;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h2D;
  localparam logic [7:0] ADDR_EVENT_EN   = 8'h2F;

  // reset values
  localparam logic [7:0] REG_RST    = 8'h00;
  localparam logic [7:0] EMPTY_BYTE = 8'h00;

  // field positions
  localparam int MODE_LSB      = 0;
  localparam int TEMP_BIT      = 2;
  localparam int HIGH_BIT      = 3;
  localparam int SYNC_BIT      = 3;
  localparam int OUTSIDE_CLOCK_SELECT_BIT   = 6;
  localparam int MEAS_LSB      = 0;
  localparam int WM_EN_BIT     = 0;
  localparam int ST_READY_BIT  = 0;
  localparam int ST_WM_BIT     = 2;
  localparam int ST_OVR_BIT    = 3;
  localparam logic [1:0] MEASURE_ON = 2'h2;

  // buffer geometry
  localparam int BUF_DEPTH   = 512;
  localparam int SETS_AXES   = 170;
  localparam int SETS_TEMP   = 128;
  localparam int PTR_W       = 9;
  localparam int CNT_W       = 10;
  localparam int ENTRY_W     = 16;
  localparam int DATA_W      = 12;
  localparam int STAGE_DEPTH = 8;

  // entry type codes
  localparam logic [1:0] TYPE_X = 2'h0;
  localparam logic [1:0] TYPE_Y = 2'h1;
  localparam logic [1:0] TYPE_Z = 2'h2;
  localparam logic [1:0] TYPE_T = 2'h3;

  // timing
  localparam int CLK_PERIOD_NS    = 10;
  localparam int SAMPLE_PERIOD_NS = 10_000_000;
  localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

  // buffer policies
  typedef enum logic [1:0] {
    SSF_MODE_OFF,
    SSF_MODE_OLDEST,
    SSF_MODE_STREAM,
    SSF_MODE_TRIG
  } ssf_mode_t;

  // sample set sequencer states
  typedef enum logic [2:0] {
    SSF_SEQ_IDLE,
    SSF_SEQ_X,
    SSF_SEQ_Y,
    SSF_SEQ_Z,
    SSF_SEQ_T
  } ssf_seq_t;

endpackage

/* File: design/ssf_stream_if.sv */
// valid and ready stream between buffer modules
`timescale 1ns/1ns
`default_nettype none
interface ssf_stream_if #(parameter int WIDTH = 16);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* File: design/ssf_stage_fifo.sv */
// small staging fifo with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ssf_stage_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic sys_rst_in,
  // synchronous discard of all words
  input  wire logic flush_in,
  // streams
  ssf_stream_if.snk push_if,
  ssf_stream_if.src pop_if
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             do_push;
  logic             do_pop;

  // honest flags and handshakes
  assign push_if.ready = (count != FULL_CNT) && !flush_in;
  assign pop_if.valid  = (count != '0) && !flush_in;
  assign pop_if.data   = mem[rd_ptr];
  assign do_push       = push_if.valid && push_if.ready;
  assign do_pop        = pop_if.valid && pop_if.ready;

  // storage write
  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      mem[wr_ptr] <= push_if.data;
    end
  end

  // pointers and fill count
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else if (flush_in) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
      end
      if (do_pop) begin
        rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
      end
      if (do_push && !do_pop) begin
        count <= count + 1'b1;
      end else if (do_pop && !do_push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/ssf_sample_buffer_properties.sv */
// port assertions of the sample buffer, bound to its top module
`timescale 1ns/1ns
`default_nettype none
module ssf_sample_buffer_properties
  import ssf_pkg::*;
#(
  parameter int EXT_DIV_P = 1
) (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       sys_rst_in,
  // host side
  input  wire logic       reg_wr_en_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       buf_rd_in,
  input  wire logic [7:0] buf_byte_out,
  // pins and events
  input  wire logic       irq_pin_one_in,
  input  wire logic       irq_pin_two_in,
  input  wire logic       watermark_out,
  input  wire logic       overrun_out,
  input  wire logic       sample_tick_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic [1:0] mode;
  logic       meas, sync, ext, wm_en, p1, p2;
  logic [3:0] off_q, cfg_q, p1_q, p2_q;
  logic       wr_cfg, sq, eq;
  // timing written now; settled sync and outside clock setups
  assign wr_cfg = reg_wr_en_in &&
    (reg_addr_in == ADDR_RATE_CTRL || reg_addr_in == ADDR_POWER_CTRL);
  assign sq = sync && meas && cfg_q >= 8;
  assign eq = ext && !sync && meas && cfg_q >= 8;
  // shadow of written settings and saturating quiet-time counters
  always_ff @(posedge sys_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      {mode, meas, sync, ext, wm_en, p1, p2} <= '0;
      {off_q, cfg_q, p1_q, p2_q} <= '0;
    end else begin
      if (reg_wr_en_in) begin
        if (reg_addr_in == ADDR_BUF_CTRL) mode <= reg_wdata_in[1:0];
        if (reg_addr_in == ADDR_RATE_CTRL) sync <= reg_wdata_in[3];
        if (reg_addr_in == ADDR_POWER_CTRL) begin
          meas <= reg_wdata_in[1:0] == MEASURE_ON;
          ext  <= reg_wdata_in[6];
        end
        if (reg_addr_in == ADDR_EVENT_EN) wm_en <= reg_wdata_in[0];
      end
      off_q <= (mode != 2'h0) ? 4'h0 : off_q + 4'(off_q != 4'hF);
      cfg_q <= wr_cfg ? 4'h0 : cfg_q + 4'(cfg_q != 4'hF);
      p1    <= irq_pin_one_in;
      p2    <= irq_pin_two_in;
      p1_q  <= (p1 != irq_pin_one_in) ? 4'h0 : p1_q + 4'(p1_q != 4'hF);
      p2_q  <= (p2 != irq_pin_two_in) ? 4'h0 : p2_q + 4'(p2_q != 4'hF);
    end
  end
  a_off_no_flags: assert property (
    off_q >= 4 |-> !watermark_out && !overrun_out)
    else $error("flag while off");
  a_off_empty_byte: assert property (
    off_q >= 4 && buf_rd_in |=> buf_byte_out == EMPTY_BYTE)
    else $error("data while off");
  a_byte_holds: assert property (
    !buf_rd_in |=> $stable(buf_byte_out))
    else $error("byte moved idle");
  a_wm_disabled: assert property (
    !wm_en [*3] |-> !watermark_out)
    else $error("wm while disabled");
  a_tick_single: assert property (
    sample_tick_out |=> !sample_tick_out)
    else $error("long tick");
  a_idle_no_tick: assert property (
    !meas [*4] |-> !sample_tick_out)
    else $error("tick in standby");
  a_sync_quiet: assert property (
    sq && p2_q >= 8 |-> !sample_tick_out)
    else $error("tick without trigger");
  a_sync_tick: assert property (
    sq && $rose(irq_pin_two_in) |-> ##[2:8] sample_tick_out)
    else $error("trigger no tick");
  a_ext_quiet: assert property (
    eq && p1_q >= 8 |-> !sample_tick_out)
    else $error("tick without clock");
  a_ext_tick: assert property (
    EXT_DIV_P == 1 && eq && $rose(irq_pin_one_in)
    |-> ##[2:8] sample_tick_out)
    else $error("clock no tick");
endmodule
bind ssf_sample_buffer ssf_sample_buffer_properties #(
  .EXT_DIV_P(EXT_DIV_P)
) i_ssf_sample_buffer_properties (
  .sys_clk_in, .sys_rst_in, .reg_wr_en_in, .reg_addr_in, .reg_wdata_in,
  .buf_rd_in, .buf_byte_out, .irq_pin_one_in, .irq_pin_two_in,
  .watermark_out, .overrun_out, .sample_tick_out
);
`default_nettype wire

/* File: tb/ssf_host_model.sv */
// host model on the register and buffer ports
`timescale 1ns/1ns
`default_nettype none
module ssf_host_model (
  // clock
  input  wire logic       sys_clk_in,
  // answers from the device
  input  wire logic [7:0] rdata_in,
  input  wire logic [7:0] byte_in,
  // requests to the device
  output var  logic       wr_en_out,
  output var  logic       rd_en_out,
  output var  logic [7:0] addr_out,
  output var  logic [7:0] wdata_out,
  output var  logic       buf_rd_out
);
  initial begin
    {wr_en_out, rd_en_out, addr_out, wdata_out, buf_rd_out} = '0;
  end
  // one register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in); #1;
    {wr_en_out, addr_out, wdata_out} = {1'b1, a, d};
    @(posedge sys_clk_in); #1;
    wr_en_out = 1'b0;
  endtask
  // one register read
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in); #1;
    {rd_en_out, addr_out} = {1'b1, a};
    @(posedge sys_clk_in); #1;
    rd_en_out = 1'b0;
    d = rdata_in;
  endtask
  // one entry, low byte first
  task automatic rd_entry(output logic [15:0] e);
    @(posedge sys_clk_in); #1;
    buf_rd_out = 1'b1;
    @(posedge sys_clk_in); #1;
    e[7:0] = byte_in;
    @(posedge sys_clk_in); #1;
    buf_rd_out = 1'b0;
    e[15:8] = byte_in;
  endtask
endmodule
`default_nettype wire

/* File: tb/ssf_sample_buffer_tb_top.sv */
// self-checking testbench of the sample buffer
`timescale 1ns/1ns
`default_nettype none
module ssf_sample_buffer_tb_top;
  import ssf_pkg::*;
  logic        sys_clk_in, sys_rst_in, pin1, pin2, act;
  logic        wr_en, rd_en, buf_rd, wm, ovr, tick;
  logic [7:0]  addr, wdata, rdata, bbyte, r;
  logic [11:0] ax, ay, az, at;
  logic [15:0] e, f;
  int          err_total, total_checks;
  ssf_host_model i_ssf_host_model (
    .sys_clk_in(sys_clk_in), .rdata_in(rdata), .byte_in(bbyte),
    .wr_en_out(wr_en), .rd_en_out(rd_en), .addr_out(addr),
    .wdata_out(wdata), .buf_rd_out(buf_rd)
  );
  ssf_sample_buffer #(
    .SAMPLE_CYCLES_P(20), .EXT_DIV_P(1)
  ) i_ssf_sample_buffer (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .reg_wr_en_in(wr_en), .reg_rd_en_in(rd_en), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .buf_rd_in(buf_rd),
    .buf_byte_out(bbyte), .axis_x_in(ax), .axis_y_in(ay), .axis_z_in(az),
    .temp_in(at), .activity_in(act), .irq_pin_one_in(pin1),
    .irq_pin_two_in(pin2), .watermark_out(wm), .overrun_out(ovr),
    .sample_tick_out(tick)
  );
  // clock generator
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  task automatic chk(input string nm, input logic [15:0] x, g);
    total_checks++;
    if (g !== x) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  function automatic logic [15:0] ent(logic [1:0] k, logic [11:0] v);
    return {k, {2{v[11]}}, v};
  endfunction
  // host model shorthands
  task automatic w(input logic [7:0] a, d);
    i_ssf_host_model.wr(a, d);
  endtask
  task automatic re();
    i_ssf_host_model.rd_entry(e);
  endtask
  task automatic get_fill();
    i_ssf_host_model.rd(ADDR_FILL_LO, f[7:0]);
    i_ssf_host_model.rd(ADDR_FILL_HI, f[15:8]);
  endtask
  // n pulses on pin two or one, x follows the count
  task automatic pulse(input int n, input bit two);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk_in); #1;
      ax = 12'(i);
      if (two) pin2 = 1'b1; else pin1 = 1'b1;
      repeat (2) @(posedge sys_clk_in);
      #1;
      {pin1, pin2} = 2'b00;
      repeat (20) @(posedge sys_clk_in);
    end
  endtask
  // buffer settings first, timing bits last
  task automatic start(input logic [7:0] c, n, input bit two);
    w(ADDR_WM_COUNT, n);
    w(ADDR_BUF_CTRL, c);
    w(ADDR_RATE_CTRL, two ? 8'h08 : 8'h00);
    w(ADDR_POWER_CTRL, two ? 8'h02 : 8'h42);
  endtask
  task automatic stop();
    w(ADDR_POWER_CTRL, 8'h00);
    w(ADDR_BUF_CTRL, 8'h00);
    get_fill();
    chk("off fill", 16'h0, f);
    re();
    chk("off entry", 16'h0, e);
  endtask
  task automatic t_reset();
    i_ssf_host_model.rd(ADDR_BUF_CTRL, r);
    chk("reset ctrl", 16'h0, 16'(r));
    get_fill();
    chk("reset fill", 16'h0, f);
    re();
    chk("empty entry", 16'h0, e);
    i_ssf_host_model.rd(8'h3F, r);
    chk("unmapped", 16'h0, 16'(r));
  endtask
  task automatic t_format();
    {ay, az, at} = {12'h123, 12'h7FF, 12'h801};
    start(8'h05, 8'h00, 1'b1);
    pulse(2, 1'b1);
    get_fill();
    chk("two sets", 16'h8, f);
    for (int s = 0; s < 2; s++) begin
      re();
      chk("x", ent(TYPE_X, 12'(s)), e);
      re();
      chk("y", ent(TYPE_Y, ay), e);
      re();
      chk("z", ent(TYPE_Z, az), e);
      re();
      chk("temp", ent(TYPE_T, at), e);
    end
    stop();
  endtask
  task automatic t_oldest();
    start(8'h01, 8'h00, 1'b1);
    pulse(SETS_AXES, 1'b1);
    get_fill();
    chk("axis sets", 16'h1FE, f);
    pulse(2, 1'b1);
    get_fill();
    chk("full fill", 16'h200, f);
    chk("full ovr", 16'h1, 16'(ovr));
    re();
    chk("oldest kept", ent(TYPE_X, 12'h0), e);
    get_fill();
    chk("pop fill", 16'h1FF, f);
    chk("pop ovr", 16'h0, 16'(ovr));
    pulse(1, 1'b1);
    get_fill();
    chk("resume fill", 16'h200, f);
    stop();
  endtask
  task automatic t_stream();
    start(8'h06, 8'h00, 1'b1);
    pulse(SETS_TEMP + 1, 1'b1);
    get_fill();
    chk("stream fill", 16'h200, f);
    chk("stream ovr", 16'h0, 16'(ovr));
    re();
    chk("oldest dropped", ent(TYPE_X, 12'h1), e);
    stop();
  endtask
  task automatic t_watermark();
    w(ADDR_EVENT_EN, 8'h01);
    start(8'h0A, 8'h00, 1'b1);
    pulse(85, 1'b1);
    chk("wm below", 16'h0, 16'(wm));
    pulse(1, 1'b1);
    chk("wm reached", 16'h1, 16'(wm));
    w(ADDR_EVENT_EN, 8'h00);
    repeat (3) @(posedge sys_clk_in);
    #1;
    chk("wm disabled", 16'h0, 16'(wm));
    stop();
  endtask
  task automatic t_trigger();
    start(8'h03, 8'h06, 1'b1);
    pulse(5, 1'b1);
    get_fill();
    chk("pre fill", 16'h6, f);
    @(posedge sys_clk_in); #1;
    act = 1'b1;
    @(posedge sys_clk_in); #1;
    act = 1'b0;
    pulse(2, 1'b1);
    get_fill();
    chk("post fill", 16'hC, f);
    stop();
  endtask
  task automatic t_ext();
    start(8'h01, 8'h00, 1'b0);
    pulse(3, 1'b0);
    get_fill();
    chk("ext fill", 16'h9, f);
    stop();
  endtask
  // watchdog
  initial begin
    #1_000_000;
    err_total++;
    complete_run();
  end
  // main sequence
  initial begin
    {sys_rst_in, pin1, pin2, act} = 4'b1000;
    {ax, ay, az, at} = '0;
    err_total = 0;
    total_checks = 0;
    repeat (20) @(posedge sys_clk_in);
    #1;
    sys_rst_in = 1'b0;
    t_reset();
    t_format();
    t_oldest();
    t_stream();
    t_watermark();
    t_trigger();
    t_ext();
    complete_run();
  end
endmodule
`default_nettype wire
